// ==== hw/fsec_fifo.sv ====
`timescale 1ns/1ps

module fsec_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);

   localparam int AW = $clog2(DEPTH);

   // Pointers wrap naturally, so depth must be a power of two
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
         $error("fsec_fifo: DEPTH must be a power of two >= 2");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_reg;
   logic [AW-1:0] rdPtr_reg;
   logic [AW:0] count_reg;
   logic doWrite;
   logic doRead;

   assign inReady = (count_reg != DEPTH[AW:0]);
   assign outValid = (count_reg != '0);
   assign outData = mem[rdPtr_reg];
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;

   // Storage carries no reset; only the pointers and the fill count need a defined value
   always_ff @(posedge clk_sys) begin
      if (doWrite) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   // Pointer and fill count
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (doWrite) begin
            wrPtr_reg <= wrPtr_reg + 1'b1;
         end
         if (doRead) begin
            rdPtr_reg <= rdPtr_reg + 1'b1;
         end
         if (doWrite && !doRead) begin
            count_reg <= count_reg + 1'b1;
         end else if (doRead && !doWrite) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

   fifo_bound_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      count_reg <= DEPTH[AW:0])
      else $error("FIFO count exceeds depth");

endmodule

// ==== hw/fsec_pkg.sv ====
package fsec_pkg;

   // Operation commands as decoded by the command sequencer
   typedef enum logic [2:0] {
      FSEC_CMD_WRITE = 3'h0,
      FSEC_CMD_RAMLOAD = 3'h1,
      FSEC_CMD_SUM = 3'h2,
      FSEC_CMD_PRODID = 3'h3,
      FSEC_CMD_STATUS = 3'h4,
      FSEC_CMD_ERASE = 3'h5,
      FSEC_CMD_PROTECT = 3'h6
   } fsec_cmd_e;

   // Handler states
   typedef enum logic [2:0] {
      FSEC_ST_IDLE = 3'h0,
      FSEC_ST_PWD = 3'h1,
      FSEC_ST_REPLY = 3'h2,
      FSEC_ST_HALT = 3'h3,
      FSEC_ST_LOOP = 3'h4
   } fsec_state_e;

   typedef logic [7:0] fsec_byte_t;

endpackage

// ==== hw/fsec_regs.svh ====
`ifndef FSEC_REGS_SVH
`define FSEC_REGS_SVH

// -----------------------------------------------------------------
// Status reply layout
// -----------------------------------------------------------------
`define FSEC_START_MARK 8'h3a
`define FSEC_PAYLOAD_COUNT 8'h04
`define FSEC_RESERVED_BYTE 8'h00
`define FSEC_REPLY_LEN 3'h7
`define FSEC_ERASED_BYTE 8'hff

// -----------------------------------------------------------------
// Status code fields and erase-area fields
// -----------------------------------------------------------------
`define FSEC_STAT_BLANK_BIT 0
`define FSEC_STAT_RP_BIT 1
`define FSEC_AREA_START_MSB 7
`define FSEC_AREA_START_LSB 4
`define FSEC_AREA_END_MSB 3
`define FSEC_AREA_END_LSB 0
`define FSEC_SECTOR_TAIL 12'hfff
`define FSEC_SECTOR_HEAD 12'h000

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define FSEC_GATE_RESET 1'b0
`define FSEC_FLAG_RESET 1'b0

`endif

// ==== hw/fsec_top.sv ====
`timescale 1ns/1ps
`include "fsec_regs.svh"

module fsec_top #(
   parameter int FIFO_DEPTH = 16,
   parameter logic [3:0] FLASH_FIRST_SECTOR = 4'hc
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic cmdValid,
   input wire logic [2:0] cmdKind,
   input wire logic [7:0] cmdByte,
   input wire logic [7:0] eraseArea,
   input wire logic pwdDone,
   input wire logic pwdOk,
   input wire logic protectNv,
   input wire logic protectSetDone,
   input wire logic scanStart,
   input wire logic scanValid,
   input wire logic [7:0] scanByte,
   output logic txValid,
   input wire logic txReady,
   output logic cmdGo,
   output logic [2:0] cmdGoKind,
   output logic sectorEraseGo,
   output logic chipEraseGo,
   output logic [15:0] eraseFirstAddr,
   output logic [15:0] eraseLastAddr,
   output logic [7:0] txData,
   output logic halted,
   output logic readProtectFlag,
   output logic blankFlag,
   input wire logic serialMode,
   input wire logic gateWrEn,
   input wire logic [7:0] gateWrData,
   output logic [7:0] gateRdData,
   output logic portInputsValid
);

   initial begin
      if (FIFO_DEPTH < 8) begin
         $error("fsec_top: FIFO must hold a whole reply");
      end
   end

   // -----------------------------------------------------------------
   // Flags and status byte
   // -----------------------------------------------------------------
   fsec_pkg::fsec_state_e state_reg;
   fsec_pkg::fsec_byte_t statusCode;
   fsec_pkg::fsec_byte_t checksum;
   logic readProtectFlag_reg;
   logic blankFlag_reg;
   logic strapDone_reg;
   logic [3:0] eraseStartNibble;
   logic [3:0] eraseEndNibble;

   assign eraseStartNibble = eraseArea[`FSEC_AREA_START_MSB:`FSEC_AREA_START_LSB];
   assign eraseEndNibble = eraseArea[`FSEC_AREA_END_MSB:`FSEC_AREA_END_LSB];

   // Upper six bits are hard zero so the code never leaves 0..3
   always_comb begin
      statusCode = 8'h00;
      statusCode[`FSEC_STAT_RP_BIT] = readProtectFlag_reg;
      statusCode[`FSEC_STAT_BLANK_BIT] = blankFlag_reg;
   end

   // Reserved bytes add nothing, so only the code enters the sum
   assign checksum = 8'(8'h00 - (statusCode + `FSEC_RESERVED_BYTE));

   // Protection flag: nonvolatile level taken once after reset release
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         strapDone_reg <= 1'b0;
         readProtectFlag_reg <= `FSEC_FLAG_RESET;
      end else begin
         strapDone_reg <= 1'b1;
         if (!strapDone_reg) begin
            readProtectFlag_reg <= protectNv;
         end else if (protectSetDone) begin
            readProtectFlag_reg <= 1'b1;
         end else if (chipEraseGo) begin
            readProtectFlag_reg <= 1'b0;
         end
      end
   end

   // Blank flag: any byte in the top area other than all-ones sets it
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         blankFlag_reg <= `FSEC_FLAG_RESET;
      end else if (scanValid && scanByte != `FSEC_ERASED_BYTE) begin
         blankFlag_reg <= 1'b1;
      end else if (scanStart) begin
         blankFlag_reg <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Command gating
   // -----------------------------------------------------------------
   logic isSector;
   logic noFlash;
   logic refuse;
   logic needPwd;
   logic [2:0] pendKind_reg;
   logic pendChip_reg;

   assign isSector = (cmdKind == fsec_pkg::FSEC_CMD_ERASE) && (eraseStartNibble <= eraseEndNibble);
   assign noFlash = eraseEndNibble < FLASH_FIRST_SECTOR;

   // Refusal and password table indexed by protect and blank flags
   always_comb begin
      refuse = 1'b0;
      needPwd = 1'b0;
      case (cmdKind)
         fsec_pkg::FSEC_CMD_WRITE, fsec_pkg::FSEC_CMD_RAMLOAD: begin
            refuse = readProtectFlag_reg;
            needPwd = !readProtectFlag_reg && blankFlag_reg;
         end
         fsec_pkg::FSEC_CMD_ERASE: begin
            // Protected sector erase is not refused: it locks up instead
            needPwd = !isSector && blankFlag_reg;
         end
         fsec_pkg::FSEC_CMD_PROTECT: begin
            refuse = !blankFlag_reg;
            needPwd = blankFlag_reg;
         end
         fsec_pkg::FSEC_CMD_SUM, fsec_pkg::FSEC_CMD_PRODID, fsec_pkg::FSEC_CMD_STATUS: begin
            refuse = 1'b0;
            needPwd = 1'b0;
         end
         default: begin
            refuse = 1'b1;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Reply path into the FIFO
   // -----------------------------------------------------------------
   logic fifoInValid;
   logic fifoInReady;
   fsec_pkg::fsec_byte_t fifoInData;
   logic fifoOutValid;
   logic fifoOutReady;
   fsec_pkg::fsec_byte_t fifoOutData;
   logic [2:0] replyIdx_reg;
   logic echoPend_reg;
   fsec_pkg::fsec_byte_t echoByte_reg;

   // Reply byte sequence; index counts bytes already pushed
   always_comb begin
      case (replyIdx_reg)
         3'h0: fifoInData = `FSEC_START_MARK;
         3'h1: fifoInData = `FSEC_PAYLOAD_COUNT;
         3'h2: fifoInData = statusCode;
         3'h6: fifoInData = checksum;
         default: fifoInData = `FSEC_RESERVED_BYTE;
      endcase
      if (echoPend_reg) begin
         fifoInData = echoByte_reg;
      end
   end

   assign fifoInValid = (state_reg == fsec_pkg::FSEC_ST_REPLY) || echoPend_reg;

   // Output stage register so the link pins come from flops
   assign fifoOutReady = !txValid || txReady;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         txValid <= 1'b0;
         txData <= 8'h00;
      end else if (fifoOutReady) begin
         txValid <= fifoOutValid;
         txData <= fifoOutData;
      end
   end

   fsec_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(fifoInData),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData)
   );

   // -----------------------------------------------------------------
   // Handler state machine
   // -----------------------------------------------------------------
   // Halt and loop states have no exit; only reset restarts the handler
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_reg <= fsec_pkg::FSEC_ST_IDLE;
         replyIdx_reg <= 3'h0;
         echoPend_reg <= 1'b0;
         echoByte_reg <= 8'h00;
         pendKind_reg <= 3'h0;
         pendChip_reg <= 1'b0;
      end else begin
         case (state_reg)
            fsec_pkg::FSEC_ST_IDLE: begin
               if (cmdValid && strapDone_reg) begin
                  pendKind_reg <= cmdKind;
                  pendChip_reg <= !isSector;
                  if (refuse) begin
                     echoPend_reg <= 1'b1;
                     echoByte_reg <= cmdByte;
                     state_reg <= fsec_pkg::FSEC_ST_HALT;
                  end else if (isSector && readProtectFlag_reg) begin
                     state_reg <= fsec_pkg::FSEC_ST_LOOP;
                  end else if (isSector && noFlash) begin
                     state_reg <= fsec_pkg::FSEC_ST_HALT;
                  end else if (needPwd) begin
                     state_reg <= fsec_pkg::FSEC_ST_PWD;
                  end else if (cmdKind == fsec_pkg::FSEC_CMD_STATUS) begin
                     replyIdx_reg <= 3'h0;
                     state_reg <= fsec_pkg::FSEC_ST_REPLY;
                  end
               end
            end
            fsec_pkg::FSEC_ST_PWD: begin
               if (pwdDone) begin
                  state_reg <= pwdOk ? fsec_pkg::FSEC_ST_IDLE : fsec_pkg::FSEC_ST_HALT;
               end
            end
            fsec_pkg::FSEC_ST_REPLY: begin
               if (fifoInReady) begin
                  replyIdx_reg <= replyIdx_reg + 3'h1;
                  if (replyIdx_reg == `FSEC_REPLY_LEN - 3'h1) begin
                     state_reg <= fsec_pkg::FSEC_ST_IDLE;
                  end
               end
            end
            fsec_pkg::FSEC_ST_HALT: begin
               if (echoPend_reg && fifoInReady) begin
                  echoPend_reg <= 1'b0;
               end
            end
            fsec_pkg::FSEC_ST_LOOP: begin
               state_reg <= fsec_pkg::FSEC_ST_LOOP;
            end
            default: begin
               state_reg <= fsec_pkg::FSEC_ST_HALT;
            end
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Grant and erase outputs
   // -----------------------------------------------------------------
   logic grantNow;
   logic grantChip;
   logic idleTake;

   assign idleTake = (state_reg == fsec_pkg::FSEC_ST_IDLE) && cmdValid && strapDone_reg && !refuse
                     && !(isSector && (readProtectFlag_reg || noFlash));
   assign grantNow = (idleTake && !needPwd) || (state_reg == fsec_pkg::FSEC_ST_PWD && pwdDone && pwdOk);
   assign grantChip = idleTake ? !isSector : pendChip_reg;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cmdGo <= 1'b0;
         cmdGoKind <= 3'h0;
         sectorEraseGo <= 1'b0;
         chipEraseGo <= 1'b0;
         eraseFirstAddr <= 16'h0000;
         eraseLastAddr <= 16'h0000;
      end else begin
         cmdGo <= grantNow;
         if (grantNow) begin
            cmdGoKind <= idleTake ? cmdKind : pendKind_reg;
         end
         sectorEraseGo <= grantNow && idleTake && isSector;
         chipEraseGo <= grantNow && (idleTake ? cmdKind : pendKind_reg) == fsec_pkg::FSEC_CMD_ERASE
                        && grantChip;
         if (idleTake && cmdKind == fsec_pkg::FSEC_CMD_ERASE) begin
            eraseFirstAddr <= {eraseStartNibble, `FSEC_SECTOR_HEAD};
            eraseLastAddr <= {eraseEndNibble, `FSEC_SECTOR_TAIL};
         end
      end
   end

   // -----------------------------------------------------------------
   // Port input gating
   // -----------------------------------------------------------------
   logic portInputGate_reg;

   // Writes outside serial mode are dropped
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         portInputGate_reg <= `FSEC_GATE_RESET;
      end else if (gateWrEn && serialMode) begin
         portInputGate_reg <= gateWrData[0];
      end
   end

   // Bits 7..1 are undefined outside serial mode; echoing write data is cheap
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         gateRdData <= 8'h00;
         portInputsValid <= 1'b1;
      end else begin
         gateRdData <= serialMode ? {7'h00, portInputGate_reg} : {gateWrData[7:1], portInputGate_reg};
         portInputsValid <= !serialMode || portInputGate_reg;
      end
   end

   assign halted = state_reg == fsec_pkg::FSEC_ST_HALT || state_reg == fsec_pkg::FSEC_ST_LOOP;
   assign readProtectFlag = readProtectFlag_reg;
   assign blankFlag = blankFlag_reg;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence refusedCmd;
      state_reg == fsec_pkg::FSEC_ST_IDLE && cmdValid && strapDone_reg && refuse;
   endsequence
   sequence echoQueued;
      echoPend_reg && fifoInValid && fifoInData == $past(cmdByte);
   endsequence

   status_code_a: assert property (statusCode[7:2] == 6'h00)
      else $error("Status code upper bits set");
   status_sum_a: assert property (8'(statusCode + checksum) == 8'h00)
      else $error("Status checksum wrong");
   reply_mark_a: assert property (fifoInValid && !echoPend_reg && replyIdx_reg == 3'h0 |->
      fifoInData == 8'h3a)
      else $error("Reply start mark wrong");
   reply_len_a: assert property (state_reg == fsec_pkg::FSEC_ST_REPLY && replyIdx_reg == 3'h6 && fifoInReady |=>
      state_reg == fsec_pkg::FSEC_ST_IDLE)
      else $error("Reply not seven bytes");
   refuse_echo_a: assert property (refusedCmd |=> echoQueued ##0 state_reg == fsec_pkg::FSEC_ST_HALT)
      else $error("Refused command not echoed");
   protect_write_a: assert property (cmdGo && readProtectFlag_reg |->
      cmdGoKind != fsec_pkg::FSEC_CMD_WRITE && cmdGoKind != fsec_pkg::FSEC_CMD_RAMLOAD)
      else $error("Write granted while protected");
   sector_loop_a: assert property (state_reg == fsec_pkg::FSEC_ST_LOOP |=>
      state_reg == fsec_pkg::FSEC_ST_LOOP && !sectorEraseGo [*3])
      else $error("Protected sector erase left loop");
   chip_unprot_a: assert property (chipEraseGo && !protectSetDone |=> !readProtectFlag_reg)
      else $error("Chip erase kept protection");
   pwd_halt_a: assert property (state_reg == fsec_pkg::FSEC_ST_PWD && pwdDone && !pwdOk |=>
      state_reg == fsec_pkg::FSEC_ST_HALT ##1 state_reg == fsec_pkg::FSEC_ST_HALT)
      else $error("Password failure not halted");
   gate_mode_a: assert property (!serialMode && gateWrEn |=> $stable(portInputGate_reg))
      else $error("Gate written outside serial mode");
   port_valid_a: assert property (serialMode && !portInputGate_reg ##1 serialMode |-> !portInputsValid)
      else $error("Port inputs valid while gated");

endmodule

// ==== tb/fsec_host_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Programming controller, receive side
// ----------------------------------------
module fsec_host_model (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic slow,
   input wire logic txValid,
   input wire logic [7:0] txData,
   output logic txReady
);
   logic [7:0] got[$];

   // Slow mode drops ready every other cycle so the reply has to wait
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         txReady <= 1'b0;
         got.delete();
      end else begin
         if (txValid && txReady) begin
            got.push_back(txData);
         end
         txReady <= slow ? ~txReady : 1'b1;
      end
   end
endmodule

// ==== tb/tb_fsec_top.sv ====
`timescale 1ns/1ps

module tb_fsec_top;
   logic clk_sys, nrst, cmdValid, pwdDone, pwdOk, protectNv, protectSetDone, scanStart, scanValid;
   logic txValid, txReady, cmdGo, sectorEraseGo, chipEraseGo, halted, readProtectFlag, blankFlag;
   logic serialMode, gateWrEn, portInputsValid, slow, go, ch, se;
   logic [2:0] cmdKind, cmdGoKind;
   logic [7:0] cmdByte, eraseArea, scanByte, txData, gateWrData, gateRdData;
   logic [15:0] eraseFirstAddr, eraseLastAddr;
   int fails, total_checks, k;

   // ----------------------------------------
   // Design and controller model
   // ----------------------------------------
   fsec_top #(.FIFO_DEPTH(16), .FLASH_FIRST_SECTOR(4'hc)) i_dut (.clk_sys, .nrst, .cmdValid, .cmdKind,
      .cmdByte, .eraseArea, .pwdDone, .pwdOk, .protectNv, .protectSetDone, .scanStart, .scanValid,
      .scanByte, .txValid, .txReady, .cmdGo, .cmdGoKind, .sectorEraseGo, .chipEraseGo, .eraseFirstAddr,
      .eraseLastAddr, .txData, .halted, .readProtectFlag, .blankFlag, .serialMode, .gateWrEn,
      .gateWrData, .gateRdData, .portInputsValid);
   fsec_host_model i_host (.clk_sys, .nrst, .slow, .txValid, .txData, .txReady);

   // Free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Reset, then scan the 32 top bytes; only the last may differ from erased
   task automatic rst(input logic rp, input logic bad);
      nrst = 1'b0;
      protectNv = rp;
      repeat (3) @(negedge clk_sys);
      nrst = 1'b1;
      repeat (2) @(negedge clk_sys);
      scanStart = 1'b1;
      @(negedge clk_sys);
      scanStart = 1'b0;
      scanValid = 1'b1;
      for (int i = 0; i < 32; i++) begin
         scanByte = (i == 31 && bad) ? 8'h5a : 8'hff;
         @(negedge clk_sys);
      end
      scanValid = 1'b0;
      @(negedge clk_sys);
      chk("protect flag", readProtectFlag, rp);
      chk("blank flag", blankFlag, bad);
      chk("halted after reset", halted, 1'b0);
   endtask

   task automatic issue(input logic [2:0] kind, input logic [7:0] b, input logic [7:0] area);
      go = 1'b0;
      ch = 1'b0;
      se = 1'b0;
      cmdValid = 1'b1;
      cmdKind = kind;
      cmdByte = b;
      eraseArea = area;
      @(negedge clk_sys);
      cmdValid = 1'b0;
   endtask

   // Grants are single-cycle pulses, so they are latched while waiting
   task automatic watch(input int n);
      repeat (n) begin
         go |= cmdGo;
         ch |= chipEraseGo;
         se |= sectorEraseGo;
         @(negedge clk_sys);
      end
   endtask

   task automatic pwd(input logic ok);
      pwdDone = 1'b1;
      pwdOk = ok;
      @(negedge clk_sys);
      pwdDone = 1'b0;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic status(input logic [1:0] code);
      logic [7:0] exp[7];
      rst(code[1], code[0]);
      slow = code[0];
      issue(fsec_pkg::FSEC_CMD_STATUS, 8'h00, 8'h00);
      for (int i = 0; i < 60 && i_host.got.size() < 7; i++) @(negedge clk_sys);
      exp = '{8'h3a, 8'h04, {6'h00, code}, 8'h00, 8'h00, 8'h00, 8'h00 - {6'h00, code}};
      chk("reply length", 16'(i_host.got.size()), 16'h0007);
      if (i_host.got.size() != 7) summarize();
      for (int i = 0; i < 7; i++) begin
         chk("reply byte", i_host.got[i], exp[i]);
      end
      slow = 1'b0;
   endtask

   task automatic good(input logic rp, input logic bad, input logic [2:0] kind, input logic [7:0] area,
                       input logic needPwd);
      rst(rp, bad);
      issue(kind, 8'h00, area);
      if (needPwd) begin
         watch(6);
         chk("early grant", go, 1'b0);
         pwd(1'b1);
      end
      watch(6);
      chk("grant", go, 1'b1);
      chk("grant kind", cmdGoKind, kind);
      if (kind == fsec_pkg::FSEC_CMD_ERASE) begin
         chk("first addr", eraseFirstAddr, {area[7:4], 12'h000});
         chk("last addr", eraseLastAddr, {area[3:0], 12'hfff});
         chk("chip erase", ch, area[7:4] > area[3:0]);
         chk("sector erase", se, area[7:4] <= area[3:0]);
         chk("protect after erase", readProtectFlag, rp && area[7:4] <= area[3:0]);
      end
      // Setting protection is confirmed by the flash side one pulse later
      if (kind == fsec_pkg::FSEC_CMD_PROTECT) begin
         protectSetDone = 1'b1;
         @(negedge clk_sys);
         protectSetDone = 1'b0;
         @(negedge clk_sys);
         chk("protect set", readProtectFlag, 1'b1);
      end
      chk("still running", halted, 1'b0);
   endtask

   task automatic refuse(input logic rp, input logic bad, input logic [2:0] kind, input logic [7:0] b,
                         input logic [7:0] area, input logic failPwd, input logic echo);
      rst(rp, bad);
      issue(kind, b, area);
      if (failPwd) begin
         pwd(1'b0);
      end
      watch(20);
      chk("refused grant", {go, ch, se}, 3'h0);
      chk("halted", halted, 1'b1);
      chk("echo count", 16'(i_host.got.size()), echo);
      if (echo && i_host.got.size() > 0) chk("echo byte", i_host.got[0], b);
   endtask

   task automatic gwr(input logic [7:0] d);
      gateWrEn = 1'b1;
      gateWrData = d;
      @(negedge clk_sys);
      gateWrEn = 1'b0;
      repeat (2) @(negedge clk_sys);
   endtask

   task automatic gate();
      rst(1'b0, 1'b0);
      chk("inputs gated", portInputsValid, 1'b0);
      gwr(8'h01);
      chk("inputs valid", portInputsValid, 1'b1);
      chk("gate readback", gateRdData[0], 1'b1);
      gwr(8'h00);
      chk("inputs regated", portInputsValid, 1'b0);
      serialMode = 1'b0;
      gwr(8'h01);
      chk("run mode inputs", portInputsValid, 1'b1);
      serialMode = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk("run mode write ignored", portInputsValid, 1'b0);
   endtask

   // Two replies through the buffer, the second issued after the first is read, while the reader stalls every other cycle
   task automatic fifo();
      rst(1'b1, 1'b1);
      slow = 1'b1;
      issue(fsec_pkg::FSEC_CMD_STATUS, 8'h00, 8'h00);
      for (int i = 0; i < 60 && i_host.got.size() < 7; i++) @(negedge clk_sys);
      repeat (4) @(negedge clk_sys);
      issue(fsec_pkg::FSEC_CMD_STATUS, 8'h00, 8'h00);
      for (int i = 0; i < 60 && i_host.got.size() < 14; i++) @(negedge clk_sys);
      repeat (4) @(negedge clk_sys);
      chk("buffered fill", 16'(i_host.got.size()), 16'h000e);
      if (i_host.got.size() == 14) begin
         chk("buffered word", i_host.got[9], 8'h03);
         chk("buffered sum", i_host.got[13], 8'hfd);
      end
      chk("buffer drained", txValid, 1'b0);
      slow = 1'b0;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      fails = 0;
      total_checks = 0;
      {nrst, cmdValid, pwdDone, pwdOk, protectNv, protectSetDone, scanStart, scanValid} = 8'h00;
      {cmdKind, cmdByte, eraseArea, scanByte, gateWrData} = 35'h0;
      {gateWrEn, slow} = 2'h0;
      serialMode = 1'b1;
      for (k = 0; k < 4; k++) status(2'(k));
      good(1'b0, 1'b0, fsec_pkg::FSEC_CMD_WRITE, 8'h00, 1'b0);
      good(1'b0, 1'b0, fsec_pkg::FSEC_CMD_RAMLOAD, 8'h00, 1'b0);
      good(1'b0, 1'b0, fsec_pkg::FSEC_CMD_SUM, 8'h00, 1'b0);
      good(1'b0, 1'b0, fsec_pkg::FSEC_CMD_PRODID, 8'h00, 1'b0);
      good(1'b0, 1'b0, fsec_pkg::FSEC_CMD_ERASE, 8'hcd, 1'b0);
      good(1'b0, 1'b1, fsec_pkg::FSEC_CMD_WRITE, 8'h00, 1'b1);
      good(1'b0, 1'b1, fsec_pkg::FSEC_CMD_RAMLOAD, 8'h00, 1'b1);
      good(1'b0, 1'b1, fsec_pkg::FSEC_CMD_PROTECT, 8'h00, 1'b1);
      good(1'b0, 1'b1, fsec_pkg::FSEC_CMD_ERASE, 8'hf0, 1'b1);
      good(1'b1, 1'b0, fsec_pkg::FSEC_CMD_ERASE, 8'hf0, 1'b0);
      good(1'b1, 1'b1, fsec_pkg::FSEC_CMD_ERASE, 8'hdc, 1'b1);
      good(1'b1, 1'b1, fsec_pkg::FSEC_CMD_PROTECT, 8'h00, 1'b1);
      good(1'b1, 1'b1, fsec_pkg::FSEC_CMD_SUM, 8'h00, 1'b0);
      refuse(1'b1, 1'b0, fsec_pkg::FSEC_CMD_WRITE, 8'h30, 8'h00, 1'b0, 1'b1);
      refuse(1'b1, 1'b1, fsec_pkg::FSEC_CMD_RAMLOAD, 8'h60, 8'h00, 1'b0, 1'b1);
      refuse(1'b0, 1'b0, fsec_pkg::FSEC_CMD_PROTECT, 8'hc2, 8'h00, 1'b0, 1'b1);
      refuse(1'b1, 1'b0, fsec_pkg::FSEC_CMD_PROTECT, 8'hc2, 8'h00, 1'b0, 1'b1);
      refuse(1'b1, 1'b1, fsec_pkg::FSEC_CMD_ERASE, 8'hd0, 8'hcd, 1'b0, 1'b0);
      refuse(1'b0, 1'b0, fsec_pkg::FSEC_CMD_ERASE, 8'hd0, 8'h12, 1'b0, 1'b0);
      refuse(1'b0, 1'b1, fsec_pkg::FSEC_CMD_WRITE, 8'h30, 8'h00, 1'b1, 1'b0);
      gate();
      fifo();
      summarize();
   end
endmodule
